// file: swire_pkg.sv
// constants, types and register map of the single-wire identity search controller
// assumes one 100 MHz clock and an open-drain bus with an external pull-up
//
// Notes on behaviour
// - mismatching slaves drop out after selection write
// - reads 0 then 1: all hold 0
// - reads 0 and 0: conflict, choose branch
// - reads 1 and 1: end pass now
// - each good pass yields one 64-bit code
// - pass is reset plus command plus bit slots
// - pass starts with reset; absent or finished clears
// - search command byte follows good presence
// - no conflict: write back the true bit
// - conflict: below repeat, at 1, above 0
// - choosing 0 at conflict records marker
// - bits stored lsb first, bytes fed to crc
// - short pass or bad crc clears position
// - success copies marker, sets finished only if marker is 0, reports found
// - start-first clears position and finished flag
// - crc of every found code is checked
// - bus level is and of all drivers
// - read, read complement, write; 64 times
// - slots 60 to 120 us, 1 us recovery
// - 480 us low reset, then presence sample
package swire_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US = 1000;
  localparam logic [15:0] TICK_DIV_RESET = 16'(NS_PER_US / CLK_PERIOD_NS);

  // bus timing in microseconds
  localparam int RESET_LOW_US = 480;
  localparam int PRESENCE_SAMPLE_US = 70;
  localparam int RESET_TOTAL_US = 960;
  localparam int SLOT_US = 61;
  localparam int RECOVERY_US = 1;
  localparam int WRITE1_LOW_US = 6;
  localparam int READ_LOW_US = 1;
  localparam int READ_SAMPLE_US = 13;
  localparam int US_W = 10;

  // search constants
  localparam logic [7:0] CMD_SEARCH = 8'hF0;
  localparam int ID_BITS = 64;
  localparam logic [6:0] POS_FIRST = 7'h01;
  localparam logic [6:0] POS_END = 7'h41;
  localparam logic [7:0] CRC_POLY_REFL = 8'h8C;

  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CODE_LO = 8'h08;
  localparam logic [7:0] OFF_CODE_HI = 8'h0C;
  localparam logic [7:0] OFF_LAST_POS = 8'h10;
  localparam logic [7:0] OFF_TICK_DIV = 8'h14;

  // field positions
  localparam int CTRL_FIRST_BIT = 0;
  localparam int CTRL_NEXT_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_FINISHED_BIT = 1;
  localparam int ST_FOUND_BIT = 2;
  localparam int ST_NODEV_BIT = 3;
  localparam int ST_CRCERR_BIT = 4;

  typedef enum logic [1:0] {SLOT_RESET, SLOT_WRITE0, SLOT_WRITE1, SLOT_READ} slot_kind_t;

  typedef struct packed {
    logic done;
    logic found;
    logic no_device;
    logic crc_error;
  } search_result_t;

endpackage

// file: swire_slot.sv
// timed slot engine: reset/presence, write 0, write 1 and read slots
// assumes dq_i is the resolved bus level, synchronous to mclk
`timescale 1ns/10ps
module swire_slot
  import swire_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic [15:0] tick_div,
  input wire logic go,
  input wire slot_kind_t kind,
  output logic done,
  output logic rx_bit,
  // bus pin
  input wire logic dq_i,
  output logic dq_o,
  output logic dq_oe
);

  logic [15:0] pre_q;
  logic [US_W-1:0] us_q;
  logic busy_q;
  slot_kind_t kind_q;
  logic us_tick;
  logic [US_W-1:0] us_next;
  logic [US_W-1:0] low_us;
  logic [US_W-1:0] sample_us;
  logic [US_W-1:0] end_us;

  // microsecond tick; a divide of 0 behaves as 1
  assign us_tick = (pre_q + 16'h0001 >= tick_div);
  assign us_next = us_q + 1'b1;
  assign low_us = (kind_q == SLOT_RESET) ? US_W'(RESET_LOW_US) :
                  (kind_q == SLOT_WRITE0) ? US_W'(SLOT_US - RECOVERY_US) :
                  (kind_q == SLOT_WRITE1) ? US_W'(WRITE1_LOW_US) : US_W'(READ_LOW_US);
  assign sample_us = (kind_q == SLOT_RESET) ? US_W'(RESET_LOW_US + PRESENCE_SAMPLE_US) :
                     US_W'(READ_SAMPLE_US);
  assign end_us = (kind_q == SLOT_RESET) ? US_W'(RESET_TOTAL_US) : US_W'(SLOT_US);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 16'h0000;
    end else if (ce) begin
      pre_q <= (!busy_q || us_tick) ? 16'h0000 : pre_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      done <= 1'b0;
      us_q <= '0;
      kind_q <= SLOT_RESET;
    end else if (ce) begin
      done <= 1'b0;
      if (go && !busy_q) begin
        busy_q <= 1'b1;
        us_q <= '0;
        kind_q <= kind;
      end else if (busy_q && us_tick) begin
        us_q <= us_next;
        if (us_next == end_us) begin
          busy_q <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  // line pulled low from slot start until its low time ends; released for recovery
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dq_oe <= 1'b0;
      dq_o <= 1'b0;
    end else if (ce) begin
      dq_o <= 1'b0;
      if (go && !busy_q) begin
        dq_oe <= 1'b1;
      end else if (busy_q && us_tick && us_next == low_us) begin
        dq_oe <= 1'b0;
      end
    end
  end

  // sampled level is the and of every driver on the wire
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_bit <= 1'b1;
    end else if (ce && busy_q && us_tick && us_q == sample_us) begin
      rx_bit <= dq_i;
    end
  end

endmodule

// file: swire_crc8.sv
// byte-wise crc-8 (reflected x^8+x^5+x^4+1) over the identity code
// assumes clear and feed are never high together
`timescale 1ns/10ps
module swire_crc8
  import swire_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // data
  input wire logic clear,
  input wire logic feed,
  input wire logic [7:0] data,
  output logic [7:0] crc_q
);

  function automatic logic [7:0] crc_byte(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      crc_q <= 8'h00;
    end else if (ce) begin
      if (clear) begin
        crc_q <= 8'h00;
      end else if (feed) begin
        crc_q <= crc_byte(crc_q, data);
      end
    end
  end

endmodule

// file: swire_search.sv
// identity search master for a shared open-drain single-wire bus
// assumes a pull-up on the wire, slaves that follow the search protocol,
// and a register master that never issues read and write together
`timescale 1ns/10ps
module swire_search
  import swire_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_q,
  // search result
  output search_result_t result_q,
  output logic [ID_BITS-1:0] code_q,
  // bus pin
  input wire logic dq_i,
  output logic dq_o,
  output logic dq_oe
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_RESET, ST_CMD, ST_RD_TRUE, ST_RD_COMP, ST_WR_SEL, ST_FINISH
  } state_t;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  state_t state_q;
  state_t state_d;
  logic [6:0] bit_pos_q;
  logic [2:0] cmd_cnt_q;
  logic true_q;
  logic sel_q;
  logic [6:0] marker_q;
  logic [6:0] last_pos_q;
  logic finished_q;
  logic no_dev_q;
  logic [ID_BITS-1:0] rom_q;
  logic [15:0] tick_div_q;
  logic go_q;
  slot_kind_t kind_q;
  logic [4:0] status_q;

  logic slot_done;
  logic slot_rx;
  logic [7:0] crc;

  // selection bit for one position
  function automatic logic pick_bit(input logic t, input logic c, input logic [6:0] pos,
                                    input logic [6:0] last, input logic prev);
    if (t != c) begin
      return t;
    end else if (pos < last) begin
      return prev;
    end else begin
      return pos == last;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire idle = (state_q == ST_IDLE);
  wire wr_ctrl = wr && addr == OFF_CTRL;
  wire start_first = idle && wr_ctrl && wdata[CTRL_FIRST_BIT];
  wire start_next = idle && wr_ctrl && wdata[CTRL_NEXT_BIT] && !wdata[CTRL_FIRST_BIT];
  wire start = start_first || start_next;
  wire rst_done = state_q == ST_RESET && slot_done;
  wire absent = slot_rx || finished_q;
  wire cmd_done = state_q == ST_CMD && slot_done;
  wire comp_done = state_q == ST_RD_COMP && slot_done;
  wire both_ones = true_q && slot_rx;
  wire conflict = !true_q && !slot_rx;
  wire sel_bit = pick_bit(true_q, slot_rx, bit_pos_q, last_pos_q, rom_q[0]);
  wire sel_done = state_q == ST_WR_SEL && slot_done;
  wire byte_end = sel_done && bit_pos_q[2:0] == 3'h0;
  wire pass_ok = bit_pos_q == POS_END && crc == 8'h00;
  wire fin = state_q == ST_FINISH;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (start) state_d = ST_RESET;
      ST_RESET: if (slot_done) state_d = absent ? ST_FINISH : ST_CMD;
      ST_CMD: if (slot_done && cmd_cnt_q == 3'h7) state_d = ST_RD_TRUE;
      ST_RD_TRUE: if (slot_done) state_d = ST_RD_COMP;
      ST_RD_COMP: if (slot_done) state_d = both_ones ? ST_FINISH : ST_WR_SEL;
      ST_WR_SEL: if (slot_done) state_d = (bit_pos_q == 7'(ID_BITS)) ? ST_FINISH : ST_RD_TRUE;
      ST_FINISH: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot requests
  wire go_d = start || (rst_done && !absent) || (state_d != state_q && !fin &&
              state_d != ST_FINISH && state_d != ST_CMD) || (cmd_done && cmd_cnt_q != 3'h7);
  wire [2:0] cmd_next = (state_q == ST_CMD) ? cmd_cnt_q + 3'h1 : 3'h0;
  wire slot_kind_t kind_d = start ? SLOT_RESET :
                           (rst_done || cmd_done && cmd_cnt_q != 3'h7) ?
                           (CMD_SEARCH[cmd_next] ? SLOT_WRITE1 : SLOT_WRITE0) :
                           comp_done ? (sel_bit ? SLOT_WRITE1 : SLOT_WRITE0) : SLOT_READ;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      go_q <= 1'b0;
      kind_q <= SLOT_RESET;
    end else if (ce) begin
      go_q <= go_d;
      kind_q <= kind_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_cnt_q <= 3'h0;
    end else if (ce && (rst_done || cmd_done)) begin
      cmd_cnt_q <= cmd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // search datapath
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      true_q <= 1'b0;
    end else if (ce && state_q == ST_RD_TRUE && slot_done) begin
      true_q <= slot_rx;
    end
  end

  // rotating the code puts the previous pass's bit for this position in bit 0
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rom_q <= '0;
      sel_q <= 1'b0;
    end else if (ce && comp_done && !both_ones) begin
      rom_q <= {sel_bit, rom_q[ID_BITS-1:1]};
      sel_q <= sel_bit;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      marker_q <= 7'h00;
    end else if (ce) begin
      if (start) begin
        marker_q <= 7'h00;
      end else if (comp_done && conflict && !sel_bit) begin
        marker_q <= bit_pos_q;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_pos_q <= POS_FIRST;
    end else if (ce) begin
      if (start) begin
        bit_pos_q <= POS_FIRST;
      end else if (sel_done) begin
        bit_pos_q <= bit_pos_q + 7'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      no_dev_q <= 1'b0;
    end else if (ce) begin
      if (start) begin
        no_dev_q <= 1'b0;
      end else if ((rst_done && absent) || (comp_done && both_ones)) begin
        no_dev_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pass outcome
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_pos_q <= 7'h00;
      finished_q <= 1'b0;
    end else if (ce) begin
      if (start_first) begin
        last_pos_q <= 7'h00;
        finished_q <= 1'b0;
      end else if (fin && !pass_ok) begin
        last_pos_q <= 7'h00;
      end else if (fin) begin
        last_pos_q <= marker_q;
        finished_q <= marker_q == 7'h00;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= '0;
      code_q <= '0;
    end else if (ce) begin
      result_q <= '0;
      if (fin) begin
        result_q.done <= 1'b1;
        result_q.found <= pass_ok;
        result_q.no_device <= no_dev_q;
        result_q.crc_error <= !no_dev_q && !pass_ok;
        if (pass_ok) begin
          code_q <= rom_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_div_q <= TICK_DIV_RESET;
    end else if (ce && wr && addr == OFF_TICK_DIV) begin
      tick_div_q <= wdata[15:0];
    end
  end

  // outcome bits hold until the next pass starts
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 5'h00;
    end else if (ce) begin
      status_q[ST_BUSY_BIT] <= state_d != ST_IDLE;
      status_q[ST_FINISHED_BIT] <= finished_q;
      if (start) begin
        status_q[ST_CRCERR_BIT:ST_FOUND_BIT] <= 3'h0;
      end else if (result_q.done) begin
        status_q[ST_FOUND_BIT] <= result_q.found;
        status_q[ST_NODEV_BIT] <= result_q.no_device;
        status_q[ST_CRCERR_BIT] <= result_q.crc_error;
      end
    end
  end

  wire [31:0] rd_mux = (addr == OFF_STATUS) ? {27'h0, status_q} :
                       (addr == OFF_CODE_LO) ? code_q[31:0] :
                       (addr == OFF_CODE_HI) ? code_q[63:32] :
                       (addr == OFF_LAST_POS) ? {25'h0, last_pos_q} :
                       (addr == OFF_TICK_DIV) ? {16'h0, tick_div_q} : 32'h0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0;
    end else if (ce) begin
      rdata_q <= rd ? rd_mux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot engine and crc
  swire_slot u_slot (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .tick_div(tick_div_q),
    .go(go_q),
    .kind(kind_q),
    .done(slot_done),
    .rx_bit(slot_rx),
    .dq_i(dq_i),
    .dq_o(dq_o),
    .dq_oe(dq_oe)
  );

  swire_crc8 u_crc (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .clear(start),
    .feed(ce && byte_end),
    .data(rom_q[ID_BITS-1 -: 8]),
    .crc_q(crc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_pair_ones;
    ce && comp_done && true_q && slot_rx;
  endsequence

  sequence s_fail_finish;
    ce && fin && !pass_ok;
  endsequence

  chk_abort_ones: assert property (s_pair_ones |=> state_q == ST_FINISH)
    else $error("pass not ended on 11 read pair");

  chk_fail_clear: assert property (s_fail_finish |=> last_pos_q == 7'h00 && result_q.done
    && !result_q.found)
    else $error("failed pass did not clear position");

  chk_success_copy: assert property (ce && fin && pass_ok |=> last_pos_q == $past(marker_q)
    && result_q.found && finished_q == ($past(marker_q) == 7'h00))
    else $error("successful pass outcome wrong");

  chk_first_clears: assert property (ce && start_first |=> last_pos_q == 7'h00
    && !finished_q && state_q == ST_RESET)
    else $error("start-first did not clear search state");

  chk_absent_ends: assert property (ce && rst_done && slot_rx |=> state_q == ST_FINISH
    ##1 last_pos_q == 7'h00 && result_q.no_device)
    else $error("missing presence not reported");

  chk_cmd_first: assert property (ce && cmd_done && cmd_cnt_q == 3'h7
    |=> state_q == ST_RD_TRUE && go_q && kind_q == SLOT_READ)
    else $error("search command not followed by bit read");

  chk_plain_select: assert property (ce && comp_done && true_q != slot_rx
    |=> sel_q == $past(true_q))
    else $error("selection bit differs from true read");

  chk_marker_zero: assert property (ce && comp_done && conflict && !sel_bit
    |=> marker_q == $past(bit_pos_q))
    else $error("conflict marker not recorded");

  chk_result_pulse: assert property (result_q.done |=> !result_q.done)
    else $error("result held longer than one cycle");

endmodule

// file: swire_slave_model.sv
// behavioural population of slave devices on the open-drain single-wire bus
// assumes one mclk cycle per microsecond (tick divider set to 1) and a pull-up on dq
`timescale 1ns/10ps
module swire_slave_model
  import swire_pkg::*;
#(
  parameter int NDEV = 4
)
(
  // clock and bus
  input wire logic mclk,
  input wire logic dq,
  output logic pull,
  // population
  input wire logic [NDEV-1:0][63:0] codes,
  input wire logic [NDEV-1:0] present
);
  logic [7:0] cmd_q;
  logic [NDEV-1:0] active;
  int phase;
  int step;
  int pos;
  int nbits;
  int len;

  function automatic logic [NDEV-1:0] column(input int p);
    logic [NDEV-1:0] c;
    for (int d = 0; d < NDEV; d++) begin
      c[d] = codes[d][p];
    end
    return c;
  endfunction

  task automatic low_len(output int n);
    n = 0;
    while (dq === 1'b0) begin
      @(posedge mclk);
      n++;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    pull = 1'b0;
    cmd_q = 8'h00;
    active = '0;
    phase = 0;
    step = 0;
    pos = 0;
    nbits = 0;
    forever begin
      @(negedge dq);
      if (phase == 2 && step < 2) begin
        // a device taken off the wire mid-pass stops answering
        active = active & present;
        // a coupled slave pulls for a 0; the wire shows the and of all of them
        pull = (step == 0) ? |(active & ~column(pos)) : |(active & column(pos));
        // held well past the master's sample point, released before the slot ends
        repeat (30) @(posedge mclk);
        pull = 1'b0;
        step++;
      end else begin
        low_len(len);
        if (len >= 400) begin
          repeat (15) @(posedge mclk);
          pull = |present;
          repeat (100) @(posedge mclk);
          pull = 1'b0;
          active = present;
          phase = 1;
          nbits = 0;
        end else if (phase == 1) begin
          // a short low is a 1; bits arrive lsb first
          cmd_q = {len < 15, cmd_q[7:1]};
          nbits++;
          if (nbits == 8) begin
            phase = (cmd_q == CMD_SEARCH) ? 2 : 0;
            step = 0;
            pos = 0;
          end
        end else if (phase == 2) begin
          active = active & ((len < 15) ? column(pos) : ~column(pos));
          pos++;
          step = 0;
          if (pos == ID_BITS) begin
            phase = 0;
          end
        end
      end
    end
  end
endmodule

// file: swire_search_tb.sv
// self-checking bench for the identity search controller
// assumes the slave model runs at one mclk cycle per microsecond
`timescale 1ns/10ps
`define CHECK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end

module swire_search_tb;
  import swire_pkg::*;

  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata_q;
  search_result_t result_q;
  logic [ID_BITS-1:0] code_q;
  logic dq_oe;
  logic slave_pull;
  logic [3:0] present = 4'h0;
  logic [3:0][63:0] codes;
  logic [31:0] rv;
  int num_errors = 0;
  int total_checks = 0;
  // open-drain wire with pull-up: high unless someone pulls
  wire logic dq_line = !(dq_oe | slave_pull);

  always #5 mclk = ~mclk;

  swire_search i_swire_search (
    .mclk(mclk), .nrst(nrst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .result_q(result_q), .code_q(code_q),
    .dq_i(dq_line), .dq_o(), .dq_oe(dq_oe)
  );

  swire_slave_model #(.NDEV(4)) i_swire_slave_model (
    .mclk(mclk), .dq(dq_line), .pull(slave_pull), .codes(codes), .present(present)
  );

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] with_crc(input logic [55:0] d);
    logic [7:0] crc;
    logic [7:0] b;
    crc = 8'h00;
    for (int i = 0; i < 7; i++) begin
      b = d[8*i +: 8];
      for (int k = 0; k < 8; k++) begin
        crc = ((crc ^ b) & 8'h01) ? ((crc >> 1) ^ CRC_POLY_REFL) : (crc >> 1);
        b = b >> 1;
      end
    end
    return {crc, d};
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata_q;
  endtask

  task automatic wait_done(input logic [3:0] exp_res, input logic [63:0] exp_code);
    int n;
    n = 0;
    // a full pass is about 13600 cycles at one cycle per microsecond
    while (result_q.done !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHECK(result_q, search_result_t'(exp_res))
    if (exp_res[2] === 1'b1) `CHECK(code_q, exp_code)
  endtask

  task automatic run_pass(input logic [31:0] ctrl, input logic [3:0] exp_res,
                          input logic [63:0] exp_code);
    reg_wr(OFF_CTRL, ctrl);
    wait_done(exp_res, exp_code);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    reg_rd(OFF_TICK_DIV, rv);
    `CHECK(rv, {16'h0000, TICK_DIV_RESET})
    reg_wr(OFF_TICK_DIV, 32'h0000_0001);
    reg_rd(OFF_TICK_DIV, rv);
    `CHECK(rv, 32'h0000_0001)
    reg_rd(8'h3C, rv);
    `CHECK(rv, 32'h0000_0000)
    reg_rd(OFF_STATUS, rv);
    `CHECK(rv, 32'h0000_0000)
  endtask

  task automatic t_absent;
    present <= 4'h0;
    reg_wr(OFF_CTRL, 32'h0000_0001);
    reg_wr(OFF_CTRL, 32'h0000_0002);
    reg_rd(OFF_STATUS, rv);
    `CHECK(rv[ST_BUSY_BIT], 1'b1)
    wait_done(4'hA, 64'h0);
    repeat (5) @(posedge mclk);
    // a second pass would show busy here if the refused start had been taken
    reg_rd(OFF_STATUS, rv);
    `CHECK(rv[4:0], 5'h08)
  endtask

  // the only device leaves after presence, so the first read pair is 11
  task automatic t_unplug;
    present <= 4'h1;
    reg_wr(OFF_CTRL, 32'h0000_0001);
    repeat (1200) @(posedge mclk);
    present <= 4'h0;
    wait_done(4'hA, 64'h0);
    reg_rd(OFF_STATUS, rv);
    `CHECK(rv[4:0], 5'h08)
  endtask

  task automatic t_search;
    present <= 4'h7;
    run_pass(32'h0000_0001, 4'hC, codes[0]);
    `CHECK(i_swire_slave_model.cmd_q, CMD_SEARCH)
    reg_rd(OFF_LAST_POS, rv);
    `CHECK(rv[6:0], 7'h03)
    run_pass(32'h0000_0002, 4'hC, codes[1]);
    reg_rd(OFF_LAST_POS, rv);
    `CHECK(rv[6:0], 7'h06)
    run_pass(32'h0000_0002, 4'hC, codes[2]);
    reg_rd(OFF_LAST_POS, rv);
    `CHECK(rv[6:0], 7'h00)
    reg_rd(OFF_STATUS, rv);
    `CHECK(rv[ST_FINISHED_BIT], 1'b1)
    run_pass(32'h0000_0002, 4'hA, 64'h0);
    reg_rd(OFF_LAST_POS, rv);
    `CHECK(rv[6:0], 7'h00)
  endtask

  // finished is still set from the full search, so only a cleared flag finds a device
  task automatic t_badcrc;
    present <= 4'h9;
    run_pass(32'h0000_0001, 4'hC, codes[0]);
    reg_rd(OFF_LAST_POS, rv);
    `CHECK(rv[6:0], 7'h01)
    // the other branch of the first position leads to the corrupted code
    run_pass(32'h0000_0002, 4'h9, 64'h0);
    reg_rd(OFF_STATUS, rv);
    `CHECK(rv[ST_FINISHED_BIT], 1'b0)
    reg_rd(OFF_LAST_POS, rv);
    `CHECK(rv[6:0], 7'h00)
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    codes[0] = with_crc(56'h00_0000_0000_000A);
    codes[1] = with_crc(56'h00_0000_0000_000E);
    codes[2] = with_crc(56'h00_0000_0000_002E);
    codes[3] = with_crc(56'h00_0000_0000_0055) ^ 64'h0100_0000_0000_0000;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_absent();
    t_unplug();
    t_search();
    t_badcrc();
    complete_run();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    complete_run();
  end
endmodule
